// >>> core/opgen_pkg.sv
// constants, field layouts and types shared by the operand address path
// assumes a 16-bit word machine with one processor clock
`default_nettype none
package opgen_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned REG_AW = 4;

  // register index map of the plain register port
  localparam logic [3:0] REG_ACC    = 4'h0;
  localparam logic [3:0] REG_AUX    = 4'h1;
  localparam logic [3:0] REG_PC     = 4'h2;
  localparam logic [3:0] REG_XCHG   = 4'h3;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_BRK    = 4'h5;
  localparam logic [3:0] REG_MASK   = 4'h6;
  localparam logic [3:0] REG_CTRL   = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_EA     = 4'h9;
  localparam logic [3:0] REG_INSTR  = 4'hA;

  // control register bits
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_M65K   = 1;
  localparam int unsigned CTRL_BPEN   = 2;
  // status register bits
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_DONE   = 1;
  localparam int unsigned STAT_BPHIT  = 2;
  localparam int unsigned STAT_OPND   = 3;

  // fixed storage locations and masks
  localparam logic [15:0] IDX2_LOC    = 16'h00FF;
  localparam logic [15:0] ADDR15_MASK = 16'h7FFF;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic [15:0] WORD_ONES   = 16'hFFFF;
  localparam logic [15:0] PC_STEP1    = 16'h0001;
  localparam logic [15:0] PC_STEP2    = 16'h0002;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam int unsigned SIGN_BIT    = 15;

  // storage reference instruction layout
  typedef struct packed {
    logic [3:0] opcode;
    logic       rel;
    logic       ind;
    logic       idx1;
    logic       idx2;
    logic [7:0] delta;
  } instr_t;

  // one word read from main storage
  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } mem_rsp_t;

endpackage : opgen_pkg
`default_nettype wire

// >>> core/ones_adder.sv
// 16-bit one's complement adder with end-around carry
// assumes purely combinational use inside the operand address path
`timescale 1ns/1ps
`default_nettype none
module ones_adder
  import opgen_pkg::*;
(
  // operands
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  // result
  output logic      [15:0] sum_o
);
  logic [16:0] raw;
  logic [15:0] wrapped;

  // carry out is folded back into bit 0; minus zero is shown as plus zero
  // so that a counter stepping past FFFE lands on 0000
  assign raw     = {1'b0, a_i} + {1'b0, b_i};
  assign wrapped = raw[15:0] + {15'h0000, raw[16]};
  assign sum_o   = (wrapped == WORD_ONES) ? WORD_ZERO : wrapped;
endmodule : ones_adder
`default_nettype wire

// >>> core/cpu_operand_address_generator.sv
// operand address path: operational registers, storage reference decode,
// base and effective address forming and program counter advance.
// assumes main storage answers each read request with an ack on this clock;
// panel switches and panel load strobe arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_address_generator
  import opgen_pkg::*;
(
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // main storage
  output logic             mem_req_o,
  output logic      [15:0] mem_addr_o,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_data_i,
  // operator panel
  input  wire logic [15:0] panel_sw_i,
  input  wire logic        panel_load_i,
  // status
  output logic             busy_o,
  output logic      [15:0] ea_o,
  output logic             bp_hit_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_WORD2, ST_IND, ST_IDX1, ST_IDX2, ST_FINISH
  } state_t;
  state_t      state_r;
  logic [15:0] acc_r;
  logic [15:0] aux_r;
  logic [15:0] pc_r;
  logic [15:0] xchg_r;
  logic [15:0] addr_r;
  logic [15:0] brk_r;
  logic [15:0] mask_r;
  logic [15:0] ea_r;
  logic [15:0] rdata_r;
  instr_t      instr_r;
  logic        m65k_r;
  logic        bpen_r;
  logic        done_r;
  logic        bphit_r;
  logic        opnd_r;
  logic        req_r;
  logic        busy_r;
  // panel synchronisers: first stage feeds only the second
  logic [15:0] sw_s1_r;
  logic [15:0] sw_s2_r;
  logic        ld_s1_r;
  logic        ld_s2_r;
  logic        ld_s3_r;
  // decode of the port
  logic wr_acc;
  logic wr_aux;
  logic wr_pc;
  logic wr_mask;
  logic wr_ctrl;
  logic wr_stat;
  logic start;
  assign wr_acc  = reg_wr_i && (reg_addr_i == REG_ACC);
  assign wr_aux  = reg_wr_i && (reg_addr_i == REG_AUX);
  assign wr_pc   = reg_wr_i && (reg_addr_i == REG_PC) && (state_r == ST_IDLE);
  assign wr_mask = reg_wr_i && (reg_addr_i == REG_MASK);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
  assign wr_stat = reg_wr_i && (reg_addr_i == REG_STATUS);
  assign start   = wr_ctrl && reg_wdata_i[CTRL_START] && (state_r == ST_IDLE);
  // instruction fields, taken from the word held after the fetch
  instr_t      ins;
  logic        dzero;
  logic [15:0] d_zext;
  logic [15:0] d_sext;
  assign ins    = instr_r;
  assign dzero  = (ins.delta == 8'h00);
  assign d_zext = {8'h00, ins.delta};
  assign d_sext = {{8{ins.delta[7]}}, ins.delta};

  // program counter adder: +1 while forming, +1 or +2 at the end
  logic [15:0] pc_step;
  logic [15:0] pc_sum;
  logic [15:0] pc_next;
  assign pc_step = (state_r == ST_FINISH && dzero) ? PC_STEP2 : PC_STEP1;
  assign pc_next = m65k_r ? pc_sum : (pc_sum & ADDR15_MASK);

  ones_adder u_pc_add (
    .a_i   (pc_r),
    .b_i   (pc_step),
    .sum_o (pc_sum)
  );

  // shared address adder; operands chosen by the current step
  logic [15:0] add_a;
  logic [15:0] add_b;
  logic [15:0] add_sum;
  assign add_a = (state_r == ST_DECODE) ? pc_r :
                 (state_r == ST_WORD2)  ? pc_sum : ea_r;
  assign add_b = (state_r == ST_DECODE) ? d_sext :
                 (state_r == ST_IDX1)   ? aux_r : mem_data_i;

  ones_adder u_ea_add (
    .a_i   (add_a),
    .b_i   (add_b),
    .sum_o (add_sum)
  );

  // indirect word handling: in 32K a set bit 15 means another level
  logic        ind_more;
  logic [15:0] ind_next;
  assign ind_more = !m65k_r && mem_data_i[SIGN_BIT];
  assign ind_next = mem_data_i & ADDR15_MASK;

  // after the base is known: choose the first indexing step
  state_t      idx_state;
  logic        idx_req;
  assign idx_state = ins.idx1 ? ST_IDX1 : (ins.idx2 ? ST_IDX2 : ST_FINISH);
  assign idx_req   = !ins.idx1 && ins.idx2;

  // state sequence, address register, request strobe, effective address
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      addr_r  <= RESET_WORD;
      ea_r    <= RESET_WORD;
      req_r   <= 1'b0;
    end else if (ce_i) begin
      req_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            addr_r  <= pc_r;
            req_r   <= 1'b1;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mem_ack_i) begin
            state_r <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (dzero) begin
            // second word carries the address or the constant
            addr_r  <= pc_sum;
            req_r   <= 1'b1;
            state_r <= ST_WORD2;
          end else if (!ins.rel && !ins.ind) begin
            ea_r    <= d_zext;
            addr_r  <= idx_req ? IDX2_LOC : addr_r;
            req_r   <= idx_req;
            state_r <= idx_state;
          end else if (!ins.rel) begin
            addr_r  <= d_zext;
            req_r   <= 1'b1;
            state_r <= ST_IND;
          end else if (!ins.ind) begin
            ea_r    <= add_sum;
            addr_r  <= idx_req ? IDX2_LOC : addr_r;
            req_r   <= idx_req;
            state_r <= idx_state;
          end else begin
            addr_r  <= add_sum;
            req_r   <= 1'b1;
            state_r <= ST_IND;
          end
        end
        ST_WORD2: begin
          if (mem_ack_i) begin
            if (ins.rel && ins.ind) begin
              addr_r  <= add_sum;
              req_r   <= 1'b1;
              state_r <= ST_IND;
            end else if (ins.ind && ind_more) begin
              addr_r  <= ind_next;
              req_r   <= 1'b1;
              state_r <= ST_IND;
            end else begin
              // constant, storage, or 16-bit relative base
              ea_r    <= ins.rel ? add_sum : mem_data_i;
              addr_r  <= idx_req ? IDX2_LOC : addr_r;
              req_r   <= idx_req;
              state_r <= idx_state;
            end
          end
        end
        ST_IND: begin
          if (mem_ack_i) begin
            if (ind_more) begin
              addr_r  <= ind_next;
              req_r   <= 1'b1;
            end else begin
              ea_r    <= mem_data_i;
              addr_r  <= idx_req ? IDX2_LOC : addr_r;
              req_r   <= idx_req;
              state_r <= idx_state;
            end
          end
        end
        ST_IDX1: begin
          ea_r    <= add_sum;
          addr_r  <= ins.idx2 ? IDX2_LOC : addr_r;
          req_r   <= ins.idx2;
          state_r <= ins.idx2 ? ST_IDX2 : ST_FINISH;
        end
        ST_IDX2: begin
          if (mem_ack_i) begin
            ea_r    <= add_sum;
            state_r <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // exchange register takes every storage word; instruction latched at fetch
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      xchg_r  <= RESET_WORD;
      instr_r <= '0;
    end else if (ce_i && mem_ack_i) begin
      xchg_r <= mem_data_i;
      if (state_r == ST_FETCH) begin
        instr_r <= instr_t'(mem_data_i);
      end
    end
  end

  // program-visible registers; pc writes only while idle to keep a walk coherent
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      acc_r  <= RESET_WORD;
      aux_r  <= RESET_WORD;
      pc_r   <= RESET_WORD;
      mask_r <= RESET_WORD;
      m65k_r <= 1'b0;
      bpen_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_acc) acc_r <= reg_wdata_i;
      if (wr_aux) aux_r <= reg_wdata_i;
      if (wr_mask) mask_r <= reg_wdata_i;
      if (wr_ctrl) begin
        m65k_r <= reg_wdata_i[CTRL_M65K];
        bpen_r <= reg_wdata_i[CTRL_BPEN];
      end
      if (state_r == ST_FINISH) begin
        pc_r <= pc_next;
      end else if (wr_pc) begin
        pc_r <= m65k_r ? reg_wdata_i : (reg_wdata_i & ADDR15_MASK);
      end
    end
  end

  // panel switches come from another world: two flops before use
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sw_s1_r <= RESET_WORD;
      sw_s2_r <= RESET_WORD;
      ld_s1_r <= 1'b0;
      ld_s2_r <= 1'b0;
      ld_s3_r <= 1'b0;
    end else if (ce_i) begin
      sw_s1_r <= panel_sw_i;
      sw_s2_r <= sw_s1_r;
      ld_s1_r <= panel_load_i;
      ld_s2_r <= ld_s1_r;
      ld_s3_r <= ld_s2_r;
    end
  end

  // breakpoint register has no program write path at all
  logic panel_load;
  assign panel_load = ld_s2_r && !ld_s3_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      brk_r <= RESET_WORD;
    end else if (ce_i && panel_load) begin
      brk_r <= sw_s2_r;
    end
  end

  // sticky status: a hardware set beats a software clear in the same cycle
  logic bp_set;
  logic done_set;
  assign bp_set   = bpen_r && (state_r == ST_FETCH) && (pc_r == brk_r);
  assign done_set = (state_r == ST_FINISH);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      done_r  <= 1'b0;
      bphit_r <= 1'b0;
      opnd_r  <= 1'b0;
      busy_r  <= 1'b0;
    end else if (ce_i) begin
      busy_r <= (state_r != ST_IDLE) || start;
      if (done_set) done_r <= 1'b1;
      else if (wr_stat && reg_wdata_i[STAT_DONE]) done_r <= 1'b0;
      if (bp_set) bphit_r <= 1'b1;
      else if (wr_stat && reg_wdata_i[STAT_BPHIT]) bphit_r <= 1'b0;
      if (done_set) opnd_r <= !ins.rel && !ins.ind && dzero;
    end
  end

  // read data selection; unmapped indices read zero
  logic [15:0] stat_word;
  logic [15:0] ctrl_word;
  logic [15:0] rd_mux;
  assign stat_word = {12'h000, opnd_r, bphit_r, done_r, busy_r};
  assign ctrl_word = {13'h0000, bpen_r, m65k_r, 1'b0};
  assign rd_mux = (reg_addr_i == REG_ACC)    ? acc_r :
                  (reg_addr_i == REG_AUX)    ? aux_r :
                  (reg_addr_i == REG_PC)     ? pc_r :
                  (reg_addr_i == REG_XCHG)   ? xchg_r :
                  (reg_addr_i == REG_ADDR)   ? addr_r :
                  (reg_addr_i == REG_BRK)    ? brk_r :
                  (reg_addr_i == REG_MASK)   ? mask_r :
                  (reg_addr_i == REG_CTRL)   ? ctrl_word :
                  (reg_addr_i == REG_STATUS) ? stat_word :
                  (reg_addr_i == REG_EA)     ? ea_r :
                  (reg_addr_i == REG_INSTR)  ? instr_r : WORD_ZERO;

  // read data stands one cycle after the strobe and only then
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_r <= RESET_WORD;
    end else if (ce_i) begin
      rdata_r <= reg_rd_i ? rd_mux : WORD_ZERO;
    end
  end
  assign reg_rdata_o = rdata_r;
  assign mem_req_o   = req_r;
  assign mem_addr_o  = addr_r;
  assign busy_o      = busy_r;
  assign ea_o        = ea_r;
  assign bp_hit_o    = bphit_r;
endmodule : cpu_operand_address_generator
`default_nettype wire

// >>> tb/opgen_monitor.sv
// port checker for the operand address path
// assumes one clock domain; bound onto the top module
`timescale 1ns/1ps
`default_nettype none
module opgen_monitor
  import opgen_pkg::*;
(
  // clock, reset, enable
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // register port
  input wire logic [3:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // main storage
  input wire logic        mem_req_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_ack_i,
  input wire logic [15:0] mem_data_i,
  // panel and status
  input wire logic [15:0] panel_sw_i,
  input wire logic        panel_load_i,
  input wire logic        busy_o,
  input wire logic [15:0] ea_o,
  input wire logic        bp_hit_o
);
  logic pend_r;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // one read in flight at a time, so the address must hold until its answer
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      pend_r <= 1'b0;
    else if (mem_req_o)
      pend_r <= 1'b1;
    else if (mem_ack_i)
      pend_r <= 1'b0;
  end
  a_acc_write_read:
    assert property ((ce_i && reg_wr_i && reg_addr_i == REG_ACC) ##1 (ce_i && reg_rd_i && reg_addr_i == REG_ACC)
      |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("accumulator read back differs");
  a_ctrl_mode_read:
    assert property ((reg_wr_i && reg_addr_i == REG_CTRL) ##1 (reg_rd_i && reg_addr_i == REG_CTRL)
      |=> reg_rdata_o == {13'h0000, $past(reg_wdata_i[2:1], 2), 1'b0}) else $error("mode bits read back differ");
  a_req_single_pulse:
    assert property (mem_req_o |=> !mem_req_o) else $error("storage request longer than one cycle");
  a_addr_held_wait:
    assert property (pend_r && !mem_req_o |-> $stable(mem_addr_o)) else $error("storage address moved while waiting");
  a_one_outstanding:
    assert property (pend_r |-> !mem_req_o) else $error("second read issued before the answer");
  a_fetch_at_start:
    assert property ($rose(busy_o) |-> ##[0:2] mem_req_o) else $error("no instruction fetch after start");
  a_ea_held_idle:
    assert property (!busy_o && !$past(busy_o) |-> $stable(ea_o)) else $error("effective address moved while idle");
  a_bp_hit_sticky:
    assert property (bp_hit_o && !(reg_wr_i && reg_addr_i == REG_STATUS && reg_wdata_i[STAT_BPHIT]) |=> bp_hit_o)
      else $error("breakpoint hit dropped without clear");
  c_walk: cover property ($rose(busy_o));
  c_answer: cover property (pend_r && mem_ack_i);
  c_bp_hit: cover property ($rose(bp_hit_o));
endmodule : opgen_monitor
bind cpu_operand_address_generator opgen_monitor opgen_monitor_i (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o),
  .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .panel_sw_i(panel_sw_i),
  .panel_load_i(panel_load_i), .busy_o(busy_o), .ea_o(ea_o), .bp_hit_o(bp_hit_o));
`default_nettype wire

// >>> tb/storage_model.sv
// behavioural main storage answering one read at a time
// assumes the bench preloads words through the mem array
`timescale 1ns/1ps
`default_nettype none
module storage_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // request side
  input  wire logic        mem_req_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        slow_i,
  // answer side
  output logic             mem_ack_o,
  output logic      [15:0] mem_data_o
);
  logic [15:0] mem [0:65535];
  logic [15:0] addr_r;
  logic        pend_r;
  logic [1:0]  wait_r;
  // data toggles outside an answer so a stale word never passes for a fresh one
  always_ff @(posedge core_clk_i) begin
    mem_ack_o <= 1'b0;
    mem_data_o <= ~mem_data_o;
    if (rst_i) begin
      pend_r <= 1'b0;
      mem_data_o <= 16'h5A5A;
    end else if (mem_req_i) begin
      pend_r <= 1'b1;
      addr_r <= mem_addr_i;
      wait_r <= slow_i ? 2'h3 : 2'h0;
    end else if (pend_r && wait_r == 2'h0) begin
      pend_r <= 1'b0;
      mem_ack_o <= 1'b1;
      mem_data_o <= mem[addr_r];
    end else if (pend_r)
      wait_r <= wait_r - 2'h1;
  end
endmodule : storage_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the operand address path
// assumes the storage model answers reads; clock enable held high except in the enable test
`timescale 1ns/1ps
`default_nettype none
module tb
  import opgen_pkg::*;
;
  logic        core_clk_i, rst_i, ce_i, reg_wr_i, reg_rd_i, panel_load_i, slow, bpen;
  logic        mem_req_o, mem_ack_i, busy_o, bp_hit_o;
  logic [3:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, panel_sw_i, reg_rdata_o, mem_addr_o, mem_data_i, ea_o;
  int          mismatches, samples_checked, cycles;
  cpu_operand_address_generator cpu_operand_address_generator_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .panel_sw_i(panel_sw_i),
    .panel_load_i(panel_load_i), .busy_o(busy_o), .ea_o(ea_o), .bp_hit_o(bp_hit_o));
  storage_model storage_model_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .slow_i(slow), .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe, so it is sampled mid-cycle there
  task automatic rchk(input string name, input logic [3:0] a, input logic [15:0] exp);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    check(name, reg_rdata_o, exp);
    @(posedge core_clk_i);
  endtask : rchk
  // mode is set before the counter is loaded, since 32K mode trims bit 15 on write
  task automatic walk(input logic m65k, input logic [15:0] pc, ins, w1, ea, npc, input logic poke);
    int n;
    storage_model_i.mem[pc] = ins;
    storage_model_i.mem[pc + 16'h0001] = w1;
    // an idle edge between two writes, so no strobe is assigned twice in one step
    @(posedge core_clk_i);
    wr(REG_CTRL, {13'h0000, bpen, m65k, 1'b0});
    @(posedge core_clk_i);
    wr(REG_PC, pc);
    @(posedge core_clk_i);
    wr(REG_CTRL, {13'h0000, bpen, m65k, 1'b1});
    if (poke) begin
      @(posedge core_clk_i);
      wr(REG_PC, 16'h0ABC);
    end
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (busy_o !== 1'b0 && n < 300);
    // a walk that never ends shows up here as a mismatch
    check("busy", {15'h0000, busy_o}, 16'h0000);
    check("ea", ea_o, ea);
    @(posedge core_clk_i);
    rchk("pc", REG_PC, npc);
  endtask : walk
  task automatic t_reset();
    for (int i = 0; i <= 10; i++) rchk("reset", 4'(i), RESET_WORD);
  endtask : t_reset
  task automatic t_regs();
    wr(REG_ACC, 16'h8001);
    rchk("acc", REG_ACC, 16'h8001);
    wr(REG_AUX, 16'h0001);
    rchk("aux", REG_AUX, 16'h0001);
    wr(REG_MASK, 16'hA5A5);
    rchk("mask", REG_MASK, 16'hA5A5);
    wr(REG_PC, 16'hFFFF);
    rchk("pc32k", REG_PC, 16'h7FFF);
    wr(REG_XCHG, 16'h1111);
    rchk("xchg", REG_XCHG, 16'h0000);
    wr(REG_ADDR, 16'h2222);
    rchk("addr", REG_ADDR, 16'h0000);
    wr(REG_BRK, 16'h3333);
    rchk("brk_prog", REG_BRK, 16'h0000);
    wr(REG_CTRL, 16'h0006);
    rchk("ctrl", REG_CTRL, 16'h0006);
    rchk("unmapped", 4'hF, 16'h0000);
  endtask : t_regs
  // a low enable must freeze the register file, so the write is lost
  task automatic t_enable();
    ce_i <= 1'b0;
    wr(REG_ACC, 16'h1234);
    ce_i <= 1'b1;
    rchk("acc_frozen", REG_ACC, 16'h8001);
  endtask : t_enable
  task automatic t_modes();
    storage_model_i.mem[16'h00FF] = 16'h0005;
    storage_model_i.mem[16'h00FD] = 16'h0500;
    storage_model_i.mem[16'h00FC] = 16'h8500;
    storage_model_i.mem[16'h0500] = 16'h1234;
    storage_model_i.mem[16'h00AC] = 16'h8102;
    storage_model_i.mem[16'h0102] = 16'h00AB;
    storage_model_i.mem[16'h4C00] = 16'h0101;
    walk(0, 16'h0100, 16'hC010, 16'h0000, 16'h0010, 16'h0101, 0);
    rchk("xchg_instr", REG_XCHG, 16'hC010);
    walk(0, 16'h0100, 16'hC110, 16'h0000, 16'h0015, 16'h0101, 0);
    rchk("xchg_idx2", REG_XCHG, 16'h0005);
    rchk("addr_idx2", REG_ADDR, 16'h00FF);
    walk(0, 16'h0100, 16'hC310, 16'h0000, 16'h0016, 16'h0101, 0);
    walk(0, 16'h0200, 16'hC000, 16'h03E8, 16'h03E8, 16'h0202, 0);
    rchk("status_opnd", REG_STATUS, 16'h000A);
    walk(0, 16'h0200, 16'hC200, 16'h03E8, 16'h03E9, 16'h0202, 0);
    walk(0, 16'h0200, 16'hC4FD, 16'h0000, 16'h0500, 16'h0201, 0);
    walk(0, 16'h0200, 16'hC4FC, 16'h0000, 16'h1234, 16'h0201, 0);
    walk(1, 16'h0200, 16'hC4FC, 16'h0000, 16'h8500, 16'h0201, 0);
    walk(0, 16'h0200, 16'hC400, 16'h8500, 16'h1234, 16'h0202, 0);
    walk(1, 16'h0200, 16'hC400, 16'h8500, 16'h8500, 16'h0202, 0);
    walk(0, 16'h0200, 16'hC805, 16'h0000, 16'h0205, 16'h0201, 0);
    walk(0, 16'h0100, 16'hC883, 16'h0000, 16'h0084, 16'h0101, 0);
    walk(0, 16'h010E, 16'hC800, 16'h0011, 16'h0120, 16'h0110, 0);
    walk(0, 16'h0100, 16'hCCAB, 16'h0000, 16'h00AB, 16'h0101, 0);
    walk(0, 16'h0100, 16'hCC00, 16'hFFFE, 16'h0101, 16'h0102, 0);
    walk(1, 16'hFFFE, 16'hC010, 16'h0000, 16'h0010, 16'h0000, 0);
  endtask : t_modes
  // the panel lines are asynchronous, so each level is held well past the synchroniser
  task automatic t_breakpoint();
    panel_sw_i <= 16'h0300;
    panel_load_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    panel_load_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    panel_sw_i <= 16'h1111;
    repeat (4) @(posedge core_clk_i);
    rchk("brk_panel", REG_BRK, 16'h0300);
    bpen = 1'b1;
    walk(0, 16'h0300, 16'hC010, 16'h0000, 16'h0010, 16'h0301, 0);
    check("bp_hit", {15'h0000, bp_hit_o}, 16'h0001);
    rchk("status_bp", REG_STATUS, 16'h0006);
    wr(REG_STATUS, 16'h0004);
    walk(0, 16'h0200, 16'hC010, 16'h0000, 16'h0010, 16'h0201, 0);
    check("bp_clear", {15'h0000, bp_hit_o}, 16'h0000);
    bpen = 1'b0;
  endtask : t_breakpoint
  task automatic t_slow();
    slow <= 1'b1;
    walk(0, 16'h0200, 16'hC4FC, 16'h0000, 16'h1234, 16'h0201, 1);
    slow <= 1'b0;
  endtask : t_slow
  task automatic end_sim();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // a hang counts as a mismatch and goes straight to the verdict
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    panel_sw_i = 16'h0000;
    panel_load_i = 1'b0;
    slow = 1'b0;
    bpen = 1'b0;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset();
    t_regs();
    t_enable();
    t_modes();
    t_breakpoint();
    t_slow();
    end_sim();
  end
endmodule : tb
`default_nettype wire
